// file: dv/io_ports_and_memory_space_select_bench.sv
/* Bench for iop_ports: registers, pins, interrupts and external bus against
   a model kept here. Assumes the memory model answers on port 1. */
`timescale 1ns/1ps
`include "iop_consts.vh"
module io_ports_and_memory_space_select_bench;
  logic mclk = 1'h0, resetn = 1'h0, rom_less = 1'h0, slow = 1'h0, timer_out = 1'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0, mem_req = 1'h0, mem_we = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, mem_wdata = 8'h00, pin_q = 8'h00;
  logic [1:0] mem_kind = 2'h0;
  logic [15:0] mem_addr = 16'h0000;
  logic [2:0] p3_in = 3'h7;
  wire [7:0] reg_rdata, mem_rdata, p0_out, p0_oe, p1_out, p1_oe, p2_out, p2_oe, drive;
  wire [7:0] p4_out, p4_oe, p5_out, p5_oe;
  wire [3:0] p3_out;
  wire mem_busy, mem_done, mem_internal, mem_refused, mem_vector, timer_in;
  wire addr_strobe_n, data_strobe_n, rw_n, strobe_oe, irq_line_zero, irq_line_one, irq_line_two;
  logic comparator_in_a = 1'h0, comparator_in_b = 1'h0;
  // Pins resolve from the device's enables
  wire [7:0] p0_in = p0_out & p0_oe | pin_q & ~p0_oe;
  wire [7:0] p1_in = p1_out & p1_oe | drive & ~p1_oe;
  wire [7:0] p2_in = p2_out & p2_oe | pin_q & ~p2_oe;
  wire [7:0] p4_in = p4_out & p4_oe | pin_q & ~p4_oe;
  wire [7:0] p5_in = p5_out & p5_oe | ~pin_q & ~p5_oe;
  int mismatches = 0, comparisons = 0, seed = 68001, n0 = 0, n1 = 0, n2 = 0;
  logic [7:0] exp_mem [int];
  logic [3:0] dira [5] = '{4'h6, 4'h7, 4'h9, 4'hc, 4'he};
  logic [3:0] data [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5};
  logic [3:0] oda [5] = '{4'h0, 4'h0, 4'ha, 4'hd, 4'hd};
  logic [7:0] odv [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02};
  iop_ports dut (.*);
  iop_mem_model mem (.*);
  initial forever #10 mclk = ~mclk;
  // Count interrupt pulses away from the edge that makes them
  always @(negedge mclk)
  begin
    n0 += irq_line_zero;
    n1 += irq_line_one;
    n2 += irq_line_two;
  end
  task check(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task results;
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task rd(logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    check("reg_rdata", e, reg_rdata & m);
  endtask
  // Result codes: 0 done, 1 internal, 2 vector, 3 refused, 4 no answer
  function int outcome(logic [1:0] k, logic [15:0] a);
    if (rom_less)
      return (k == 2'h2 && a < 16'h000c) ? 3 : 0;
    if (k == 2'h0 && a < 16'h000c)
      return 2;
    if (a >= 16'h6000)
      return 0;
    return k == 2'h2 ? 3 : 1;
  endfunction
  function logic [7:0] mem_val(logic [15:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : a[7:0] ^ a[15:8];
  endfunction
  function logic [15:0] pins(int p);
    case (p)
      0: return {p0_oe, p0_out};
      1: return {p1_oe, p1_out};
      2: return {p2_oe, p2_out};
      3: return {p4_oe, p4_out};
      default: return {p5_oe, p5_out};
    endcase
  endfunction
  task mreq(logic [1:0] k, logic w, logic [15:0] a, logic [7:0] d);
    int got;
    got = 4;
    @(posedge mclk);
    mem_req <= 1'h1;
    mem_kind <= k;
    mem_we <= w;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge mclk);
    mem_req <= 1'h0;
    // One-clock answers stand only in the cycle right after the take
    for (int i = 0; i < 40 && got == 4; i++)
    begin
      #1;
      if (mem_vector) got = 2;
      else if (mem_refused) got = 3;
      else if (mem_internal) got = 1;
      else if (mem_done) got = 0;
      @(posedge mclk);
    end
    check("mem result", outcome(k, a), got);
    if (got == 4) results;
  endtask
  initial
  begin
    logic [7:0] d, v;
    logic [15:0] a;
    logic [1:0] k;
    cyc(8);
    resetn <= 1'h1;
    for (int i = 6; i < 15; i++)
      rd(i[3:0], 8'hff, (i == 8 || i == 10 || i == 11 || i == 13) ? 8'h00 : 8'hff);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h80, 8'h00);
    // Per-bit direction on ports 0, 1, 2, 4 and 5, open drain where it exists
    for (int p = 0; p < 5; p++)
    begin
      d = $random(seed);
      v = $random(seed);
      pin_q <= $random(seed);
      wr(dira[p], d);
      wr(data[p], v);
      if (p > 1) wr(oda[p], odv[p]);
      cyc(3);
      check("pins", {p > 1 ? ~d & ~v : ~d, v & ~d}, pins(p) & {8'hff, ~d});
      rd(dira[p], 8'hff, d);
    end
    // Plain control lines, then pin reads
    wr(4'ha, 8'h00);
    v = $random(seed);
    wr(4'h3, v);
    p3_in <= v[2:0];
    cyc(6);
    check("p3_out", v[7:4], p3_out);
    rd(4'h3, 8'h0e, {4'h0, v[2:0], 1'h0});
    p3_in <= 3'h7;
    cyc(8);
    // Every edge selection, both pin edges on all three lines
    for (int es = 0; es < 4; es++)
    begin
      wr(4'hb, {es[1:0], 6'h00});
      n0 = 0;
      n1 = 0;
      n2 = 0;
      p3_in <= 3'h0;
      cyc(10);
      p3_in <= 3'h7;
      cyc(10);
      check("irq two", (es != 2) + es[1], n2);
      check("irq zero", (es != 1) + es[0], n0);
      check("irq one", 16'h0001, n1);
    end
    wr(4'ha, 8'h02);
    rd(4'h3, 8'h08, 8'h00);
    n2 = 0;
    comparator_in_a <= 1'h1;
    cyc(8);
    check("irq two", 16'h0001, n2);
    rd(4'hf, 8'h10, 8'h10);
    // Handshakes: port 0 input on P32/P35, port 2 output on P31/P36
    wr(4'h6, 8'hff);
    wr(4'h9, 8'h00);
    wr(4'ha, 8'h14);
    p3_in <= 3'h4;
    cyc(6);
    wr(4'h2, v);
    cyc(2);
    check("hs lines", 16'h0000, p3_out[2:1]);
    rd(4'h0, 8'hff, pin_q);
    p3_in <= 3'h7;
    cyc(8);
    check("hs lines", 16'h0003, p3_out[2:1]);
    // Timer lines
    wr(4'ha, 8'h40);
    v = $random(seed);
    timer_out <= v[0];
    cyc(3);
    check("timer out", v[0], p3_out[2]);
    check("timer in", p3_in[0], timer_in);
    // External bus over every kind and address class, prompt then slow
    for (int pass = 0; pass < 2; pass++)
    begin
      wr(4'h8, pass ? 8'h17 : 8'h07);
      wr(4'ha, 8'h20);
      slow <= pass[0];
      for (int i = 0; i < 12; i++)
      begin
        a = $random(seed);
        k = i % 3;
        case (i % 4)
          0: a = a % 12;
          1: a = 16'h5fff;
          2: a = 16'h6000;
        endcase
        if (k == 2'h2)
        begin
          v = $random(seed);
          mreq(k, 1'h1, a, v);
          if (outcome(k, a) == 0) exp_mem[a] = v;
        end
        mreq(k, 1'h0, a, 8'h00);
        if (outcome(k, a) == 0) check("mem_rdata", mem_val(a), mem_rdata);
      end
    end
    wr(4'h8, 8'h0f);
    cyc(3);
    check("float oe", 16'h0000, {p0_oe, p1_oe});
    check("strobe oe", 1'h0, strobe_oe);
    // External-only strap
    rom_less <= 1'h1;
    resetn <= 1'h0;
    cyc(8);
    resetn <= 1'h1;
    rd(4'h8, 8'hff, 8'h13);
    check("p0 oe", 8'hff, p0_oe);
    wr(4'h8, 8'h17);
    mreq(2'h0, 1'h0, 16'h0100, 8'h00);
    check("mem_rdata", mem_val(16'h0100), mem_rdata);
    mreq(2'h2, 1'h0, 16'h000b, 8'h00);
    results;
  end
endmodule // io_ports_and_memory_space_select_bench

// file: dv/iop_checker.sv
/* Assertions on the port block's bus cycle, space decode, float and P33 interrupt.
   Bound to iop_ports running its default wait counts. */
`timescale 1ns/1ps
`include "iop_consts.vh"
module iop_checker (
  // Clock, reset, strap
  input logic mclk,
  input logic resetn,
  input logic rom_less,
  // Memory request
  input logic mem_req,
  input logic [1:0] mem_kind,
  input logic [15:0] mem_addr,
  input logic mem_busy,
  input logic mem_done,
  input logic mem_internal,
  input logic mem_refused,
  input logic mem_vector,
  // Pins
  input logic [7:0] p0_oe,
  input logic [7:0] p1_oe,
  input logic [2:0] p3_in,
  input logic [3:0] p3_out,
  input logic addr_strobe_n,
  input logic data_strobe_n,
  input logic strobe_oe,
  input logic irq_line_one
);
  logic [15:0] addr_q;
  logic [1:0] kind_q;
  wire take = mem_req && !mem_busy;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Keep the request so later pulses can be traced back to it
  always @(posedge mclk)
    if (take)
    begin
      addr_q <= mem_addr;
      kind_q <= mem_kind;
    end
  a_take_answered:
    assert property (take |=> mem_internal || mem_refused || mem_vector || mem_busy)
    else $error("request not answered");
  a_cycle_bound:
    assert property ($rose(mem_busy) |-> ##[2:20] mem_done)
    else $error("external cycle too long");
  a_as_before_ds:
    assert property ($fell(data_strobe_n) |-> !$past(addr_strobe_n))
    else $error("data strobe without address strobe");
  a_dm_data_only:
    assert property ($fell(p3_out[0]) && mem_busy |-> kind_q == `IOP_K_DATA)
    else $error("data select on a program cycle");
  a_p33_falling:
    assert property (irq_line_one |-> !$past(p3_in[2]))
    else $error("P33 request on a high pin");
  a_vector_low:
    assert property (mem_vector |-> addr_q < `IOP_VEC_END)
    else $error("vector flag above vector space");
  a_internal_rom:
    assert property (mem_internal |-> !rom_less && addr_q < `IOP_EXT_BASE)
    else $error("internal access out of ROM range");
  a_data_refused:
    assert property (take && mem_kind == `IOP_K_DATA && !rom_less && mem_addr < `IOP_EXT_BASE
      |=> mem_refused)
    else $error("low data access not refused");
  a_float_all:
    assert property (!strobe_oe |-> p0_oe == 8'h00 && p1_oe == 8'h00)
    else $error("ports driven while strobes float");
  a_romless_addr:
    assert property ($rose(resetn) && rom_less |-> ##[1:2] p0_oe == 8'hff)
    else $error("high address port idle after reset");
  c_ext_done: cover property (mem_done);
  c_refused: cover property (mem_refused);
  c_p33_irq: cover property (irq_line_one);
endmodule // iop_checker
bind iop_ports iop_checker chk (.mclk, .resetn, .rom_less, .mem_req, .mem_kind, .mem_addr,
  .mem_busy, .mem_done, .mem_internal, .mem_refused, .mem_vector, .p0_oe, .p1_oe, .p3_in,
  .p3_out, .addr_strobe_n, .data_strobe_n, .strobe_oe, .irq_line_one);

// file: dv/iop_mem_model.sv
/* External memory on the multiplexed bus, prompt or slow.
   Assumes the high address byte on port 0 and the low byte on port 1. */
`timescale 1ns/1ps
module iop_mem_model (
  // Clock and answer speed
  input logic mclk,
  input logic slow,
  // Bus from the device
  input logic addr_strobe_n,
  input logic data_strobe_n,
  input logic rw_n,
  input logic [7:0] p0_out,
  input logic [7:0] p1_out,
  // Level offered to port 1
  output logic [7:0] drive
);
  logic [7:0] mem [int];
  logic [15:0] addr_q;
  logic [7:0] last_q = 8'h5a;
  logic [7:0] rd_q = 8'h00;
  logic as_q = 1'h1;
  int wait_q = 0;
  // Address counts at the first low cycle of the strobe
  always @(posedge mclk)
  begin
    as_q <= addr_strobe_n;
    if (!addr_strobe_n && as_q)
      addr_q <= {p0_out, p1_out};
    if (!data_strobe_n && !rw_n)
      mem[addr_q] = p1_out;
    rd_q <= mem.exists(addr_q) ? mem[addr_q] : addr_q[7:0] ^ addr_q[15:8];
    wait_q <= data_strobe_n ? 0 : wait_q + 1;
    last_q <= drive;
  end
  // Slow part answers late; a released bus never holds stale data
  assign drive = (!data_strobe_n && rw_n && (!slow || wait_q > 3)) ? rd_q : ~last_q;
endmodule // iop_mem_model

// file: include/iop_consts.vh
/*
  Register offsets, field positions, reset values and bus timing counts
  for the I/O port block. Assumes an 8-bit register port with 4-bit address.
*/
`ifndef IOP_CONSTS_VH
`define IOP_CONSTS_VH

// Register offsets
`define IOP_R_P0_DATA 4'h0
`define IOP_R_P1_DATA 4'h1
`define IOP_R_P2_DATA 4'h2
`define IOP_R_P3_DATA 4'h3
`define IOP_R_P4_DATA 4'h4
`define IOP_R_P5_DATA 4'h5
`define IOP_R_P0_DIR 4'h6
`define IOP_R_P1_DIR 4'h7
`define IOP_R_P01_MODE 4'h8
`define IOP_R_P2_DIR 4'h9
`define IOP_R_P3_MODE 4'ha
`define IOP_R_IRQ_EDGE 4'hb
`define IOP_R_P4_DIR 4'hc
`define IOP_R_P45_DRIVE 4'hd
`define IOP_R_P5_DIR 4'he
`define IOP_R_STATUS 4'hf

// Bus mode fields
`define IOP_B_P0_LO_ADDR 0
`define IOP_B_P0_HI_ADDR 1
`define IOP_B_P1_BUS 2
`define IOP_B_FLOAT 3
`define IOP_B_EXT_TIME 4

// Control port mode fields
`define IOP_B_P2_OD 0
`define IOP_B_ANALOG 1
`define IOP_B_P0_HS 2
`define IOP_B_P1_HS 3
`define IOP_B_P2_HS 4
`define IOP_B_DM_EN 5
`define IOP_B_TOUT_EN 6

// Edge select fields
`define IOP_B_EDGE_P32 6
`define IOP_B_EDGE_P31 7

// Reset values
`define IOP_RST_DIR 8'hff
`define IOP_RST_ZERO 8'h00
`define IOP_RST_P01_ROMLESS 8'h13
`define IOP_RST_P01_ROM 8'h00

// Memory map
`define IOP_EXT_BASE 16'h6000
`define IOP_VEC_END 16'h000c

// Access kinds
`define IOP_K_FETCH 2'h0
`define IOP_K_PROG 2'h1
`define IOP_K_DATA 2'h2

// Bus cycle lengths in clocks
`define IOP_BUS_WAIT 8'h06
`define IOP_EXT_WAIT 8'h08

`endif

// file: verilog/iop_ports.v
/*
  I/O ports with handshake, control port alternate functions, edge
  interrupt detection and external memory bus with space decode.
  Assumes one 50 MHz clock, a core that issues one memory request at a
  time and a register master that never issues both strobes together.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "iop_consts.vh"

module iop_ports #(
  parameter ROM_PROTECT = 0,
  parameter [7:0] BUS_WAIT = `IOP_BUS_WAIT,
  parameter [7:0] EXT_WAIT = `IOP_EXT_WAIT
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  input wire rom_less,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Memory request from core
  input wire mem_req,
  input wire [1:0] mem_kind,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  output wire mem_busy,
  output reg mem_done,
  output reg [7:0] mem_rdata,
  output reg mem_internal,
  output reg mem_refused,
  output reg mem_vector,
  // Port pins
  input wire [7:0] p0_in,
  output reg [7:0] p0_out,
  output reg [7:0] p0_oe,
  input wire [7:0] p1_in,
  output reg [7:0] p1_out,
  output reg [7:0] p1_oe,
  input wire [7:0] p2_in,
  output reg [7:0] p2_out,
  output reg [7:0] p2_oe,
  input wire [2:0] p3_in,
  output reg [3:0] p3_out,
  input wire [7:0] p4_in,
  output reg [7:0] p4_out,
  output reg [7:0] p4_oe,
  input wire [7:0] p5_in,
  output reg [7:0] p5_out,
  output reg [7:0] p5_oe,
  // Bus strobes
  output reg addr_strobe_n,
  output reg data_strobe_n,
  output reg rw_n,
  output reg strobe_oe,
  // Comparator results from the analog front end
  input wire comparator_in_a,
  input wire comparator_in_b,
  // Timer and interrupt side
  output reg timer_in,
  input wire timer_out,
  output reg irq_line_zero,
  output reg irq_line_one,
  output reg irq_line_two
);

  localparam S_IDLE = 2'd0;
  localparam S_ADDR = 2'd1;
  localparam S_DATA = 2'd2;
  localparam S_END = 2'd3;
  localparam NIN = 45;

  // Read value: pin for input bits, latch for output bits
  function [7:0] rd_mix;
    input [7:0] dir;
    input [7:0] pin;
    input [7:0] dat;
    begin
      rd_mix = (dir & pin) | (~dir & dat);
    end
  endfunction

  // Enable for push-pull or open-drain outputs
  function [7:0] drv_oe;
    input [7:0] dir;
    input od;
    input [7:0] dat;
    begin
      drv_oe = od ? (~dir & ~dat) : ~dir;
    end
  endfunction

  reg [7:0] p0_dq, p1_dq, p2_dq, p3_dq, p4_dq, p5_dq;
  reg [7:0] p0_dir_q, p1_dir_q, p2_dir_q, p4_dir_q, p5_dir_q;
  reg [7:0] p01m_q, p3m_q, edge_q, p45d_q;
  reg romless_q;
  reg [NIN-1:0] s1_q, s2_q, s3_q, f_q;
  reg [2:0] src_prev_q;
  reg [2:0] hs_dav_n_q, hs_rdy_q, hs_prev_q;
  reg [7:0] hs_lat_q [0:2];
  reg [1:0] st_q;
  reg [7:0] cnt_q;
  reg [15:0] ba_q;
  reg [7:0] bw_q;
  reg bwe_q, bdm_q;
  integer i;

  // Filtered pins
  wire [7:0] f_p0 = f_q[7:0];
  wire [7:0] f_p1 = f_q[15:8];
  wire [7:0] f_p2 = f_q[23:16];
  wire [7:0] f_p4 = f_q[31:24];
  wire [7:0] f_p5 = f_q[39:32];
  wire [2:0] f_p3 = f_q[42:40];
  wire f_ca = f_q[43];
  wire f_cb = f_q[44];
  wire analog = p3m_q[`IOP_B_ANALOG];
  wire p1_bus = p01m_q[`IOP_B_P1_BUS];
  wire bus_float = p01m_q[`IOP_B_FLOAT];

  // Handshake wiring: P0 on P32/P35, P1 on P33/P34, P2 on P31/P36
  wire [2:0] hs_en = {p3m_q[`IOP_B_P2_HS], p3m_q[`IOP_B_P1_HS] & ~p1_bus,
                      p3m_q[`IOP_B_P0_HS]};
  wire [2:0] hs_outdir = {~p2_dir_q[7], ~p1_dir_q[7], ~p0_dir_q[7]};
  wire [2:0] hs_pin = {f_p3[0], f_p3[2], f_p3[1]};
  wire [2:0] hs_line = hs_outdir & hs_dav_n_q | ~hs_outdir & hs_rdy_q;
  wire [2:0] hs_wr;
  wire [2:0] hs_rd;
  wire [7:0] hs_data [0:2];
  assign hs_wr[0] = reg_wr && reg_addr == `IOP_R_P0_DATA;
  assign hs_wr[1] = reg_wr && reg_addr == `IOP_R_P1_DATA;
  assign hs_wr[2] = reg_wr && reg_addr == `IOP_R_P2_DATA;
  assign hs_rd[0] = reg_rd && reg_addr == `IOP_R_P0_DATA;
  assign hs_rd[1] = reg_rd && reg_addr == `IOP_R_P1_DATA;
  assign hs_rd[2] = reg_rd && reg_addr == `IOP_R_P2_DATA;
  assign hs_data[0] = f_p0;
  assign hs_data[1] = f_p1;
  assign hs_data[2] = f_p2;

  // Interrupt sources, comparators replace P31/P32 in analog mode
  wire src31 = analog ? f_ca : f_p3[0];
  wire src32 = analog ? f_cb : f_p3[1];
  wire [2:0] src_now = {f_p3[2], src32, src31};
  wire [2:0] rise = src_now & ~src_prev_q;
  wire [2:0] fall = ~src_now & src_prev_q;
  wire e6 = edge_q[`IOP_B_EDGE_P32];
  wire e7 = edge_q[`IOP_B_EDGE_P31];

  // Memory space decode
  wire is_load = mem_kind != `IOP_K_FETCH;
  wire below_ext = mem_addr < `IOP_EXT_BASE;
  wire in_vec = mem_addr < `IOP_VEC_END;
  wire go_ext = romless_q | ~below_ext;
  wire bad_data = mem_kind == `IOP_K_DATA &&
                  (romless_q ? in_vec : below_ext);
  wire blocked = (ROM_PROTECT != 0) && is_load;
  wire no_bus = go_ext && !p1_bus;
  wire take = mem_req && st_q == S_IDLE;
  assign mem_busy = st_q != S_IDLE;

  // Three-stage pin sync, value changes once stages two and three agree.
  // Runs through reset so the filter has settled to the pins at release.
  always @(posedge mclk)
  begin
    s1_q <= {comparator_in_b, comparator_in_a, p3_in, p5_in, p4_in, p2_in, p1_in, p0_in};
    s2_q <= s1_q;
    s3_q <= s2_q;
    f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
  end

  // Register writes; reset state follows the ROM-less strap
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      romless_q <= rom_less;
      p0_dq <= `IOP_RST_ZERO;
      p1_dq <= `IOP_RST_ZERO;
      p2_dq <= `IOP_RST_ZERO;
      p3_dq <= `IOP_RST_ZERO;
      p4_dq <= `IOP_RST_ZERO;
      p5_dq <= `IOP_RST_ZERO;
      p0_dir_q <= `IOP_RST_DIR;
      p1_dir_q <= `IOP_RST_DIR;
      p2_dir_q <= `IOP_RST_DIR;
      p4_dir_q <= `IOP_RST_DIR;
      p5_dir_q <= `IOP_RST_DIR;
      p01m_q <= rom_less ? `IOP_RST_P01_ROMLESS : `IOP_RST_P01_ROM;
      p3m_q <= `IOP_RST_ZERO;
      edge_q <= `IOP_RST_ZERO;
      p45d_q <= `IOP_RST_ZERO;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `IOP_R_P0_DATA)
        p0_dq <= reg_wdata;
      else if (reg_addr == `IOP_R_P1_DATA)
        p1_dq <= reg_wdata;
      else if (reg_addr == `IOP_R_P2_DATA)
        p2_dq <= reg_wdata;
      else if (reg_addr == `IOP_R_P3_DATA)
        p3_dq <= {reg_wdata[7:4], 4'h0};
      else if (reg_addr == `IOP_R_P4_DATA)
        p4_dq <= reg_wdata;
      else if (reg_addr == `IOP_R_P5_DATA)
        p5_dq <= reg_wdata;
      else if (reg_addr == `IOP_R_P0_DIR)
        p0_dir_q <= reg_wdata;
      else if (reg_addr == `IOP_R_P1_DIR)
        p1_dir_q <= reg_wdata;
      else if (reg_addr == `IOP_R_P01_MODE)
        p01m_q <= {3'h0, reg_wdata[4:0]};
      else if (reg_addr == `IOP_R_P2_DIR)
        p2_dir_q <= reg_wdata;
      else if (reg_addr == `IOP_R_P3_MODE)
        p3m_q <= {1'b0, reg_wdata[6:0]};
      else if (reg_addr == `IOP_R_IRQ_EDGE)
        edge_q <= {reg_wdata[7:6], 6'h00};
      else if (reg_addr == `IOP_R_P4_DIR)
        p4_dir_q <= reg_wdata;
      else if (reg_addr == `IOP_R_P45_DRIVE)
        p45d_q <= {6'h00, reg_wdata[1:0]};
      else if (reg_addr == `IOP_R_P5_DIR)
        p5_dir_q <= reg_wdata;
    end
  end

  // Register reads, one cycle after the strobe; zero in cycles without a read
  always @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (reg_addr == `IOP_R_P0_DATA)
      reg_rdata <= hs_en[0] & ~hs_outdir[0] ? hs_lat_q[0] : rd_mix(p0_dir_q, f_p0, p0_dq);
    else if (reg_addr == `IOP_R_P1_DATA)
      reg_rdata <= hs_en[1] & ~hs_outdir[1] ? hs_lat_q[1] : rd_mix(p1_dir_q, f_p1, p1_dq);
    else if (reg_addr == `IOP_R_P2_DATA)
      reg_rdata <= hs_en[2] & ~hs_outdir[2] ? hs_lat_q[2] : rd_mix(p2_dir_q, f_p2, p2_dq);
    else if (reg_addr == `IOP_R_P3_DATA)
      reg_rdata <= {p3_dq[7:4], analog ? 1'b0 : f_p3[2], f_p3[1:0], 1'b0};
    else if (reg_addr == `IOP_R_P4_DATA)
      reg_rdata <= rd_mix(p4_dir_q, f_p4, p4_dq);
    else if (reg_addr == `IOP_R_P5_DATA)
      reg_rdata <= rd_mix(p5_dir_q, f_p5, p5_dq);
    else if (reg_addr == `IOP_R_P0_DIR)
      reg_rdata <= p0_dir_q;
    else if (reg_addr == `IOP_R_P1_DIR)
      reg_rdata <= p1_dir_q;
    else if (reg_addr == `IOP_R_P01_MODE)
      reg_rdata <= p01m_q;
    else if (reg_addr == `IOP_R_P2_DIR)
      reg_rdata <= p2_dir_q;
    else if (reg_addr == `IOP_R_P3_MODE)
      reg_rdata <= p3m_q;
    else if (reg_addr == `IOP_R_IRQ_EDGE)
      reg_rdata <= edge_q;
    else if (reg_addr == `IOP_R_P4_DIR)
      reg_rdata <= p4_dir_q;
    else if (reg_addr == `IOP_R_P45_DRIVE)
      reg_rdata <= p45d_q;
    else if (reg_addr == `IOP_R_P5_DIR)
      reg_rdata <= p5_dir_q;
    else
      reg_rdata <= {romless_q, mem_busy, f_cb, f_ca, 1'b0, hs_line};
  end

  // Handshakes: output side drops valid on write and lifts it once ready
  // is seen; input side latches on valid falling and drops ready until read.
  // Hardware capture wins over a read in the same cycle.
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      hs_dav_n_q <= 3'h7;
      hs_rdy_q <= 3'h7;
      hs_prev_q <= hs_pin;
      for (i = 0; i < 3; i = i + 1)
        hs_lat_q[i] <= 8'h00;
    end
    else
    begin
      hs_prev_q <= hs_pin;
      for (i = 0; i < 3; i = i + 1)
      begin
        if (!hs_en[i])
        begin
          hs_dav_n_q[i] <= 1'b1;
          hs_rdy_q[i] <= 1'b1;
        end
        else if (hs_outdir[i])
        begin
          if (hs_wr[i])
            hs_dav_n_q[i] <= 1'b0;
          else if (!hs_dav_n_q[i] && hs_pin[i])
            hs_dav_n_q[i] <= 1'b1;
        end
        else
        begin
          if (hs_rdy_q[i] && hs_prev_q[i] && !hs_pin[i])
          begin
            hs_lat_q[i] <= hs_data[i];
            hs_rdy_q[i] <= 1'b0;
          end
          else if (hs_rd[i])
            hs_rdy_q[i] <= 1'b1;
        end
      end
    end
  end

  // Edge interrupts as one-cycle pulses
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      src_prev_q <= src_now; // Track pins so release makes no false edge
      irq_line_zero <= 1'b0;
      irq_line_one <= 1'b0;
      irq_line_two <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_now;
      irq_line_zero <= (rise[1] & e6) | (fall[1] & (~e6 | e7));
      irq_line_two <= (rise[0] & e7) | (fall[0] & (~e7 | e6));
      irq_line_one <= fall[2] & ~analog;
    end
  end

  // External memory cycle; refused or internal requests answer in one clock
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      st_q <= S_IDLE;
      cnt_q <= 8'h00;
      ba_q <= 16'h0000;
      bw_q <= 8'h00;
      bwe_q <= 1'b0;
      bdm_q <= 1'b0;
      mem_done <= 1'b0;
      mem_rdata <= 8'h00;
      mem_internal <= 1'b0;
      mem_refused <= 1'b0;
      mem_vector <= 1'b0;
    end
    else
    begin
      mem_done <= 1'b0;
      mem_internal <= 1'b0;
      mem_refused <= 1'b0;
      mem_vector <= take && mem_kind == `IOP_K_FETCH && in_vec;
      case (st_q)
        S_IDLE:
        begin
          if (take)
          begin
            if (blocked || bad_data || no_bus)
              mem_refused <= 1'b1;
            else if (!go_ext)
              mem_internal <= 1'b1;
            else
            begin
              st_q <= S_ADDR;
              ba_q <= mem_addr;
              bw_q <= mem_wdata;
              bwe_q <= mem_we;
              bdm_q <= mem_kind == `IOP_K_DATA;
            end
          end
        end
        S_ADDR:
        begin
          st_q <= S_DATA;
          cnt_q <= p01m_q[`IOP_B_EXT_TIME] ? BUS_WAIT + EXT_WAIT : BUS_WAIT;
        end
        S_DATA:
        begin
          if (cnt_q <= 8'h01)
            st_q <= S_END;
          else
            cnt_q <= cnt_q - 8'h01;
        end
        default:
        begin
          mem_rdata <= bwe_q ? 8'h00 : f_p1;
          mem_done <= 1'b1;
          bdm_q <= 1'b0;
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Registered pin drive
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p1_out <= 8'h00;
      p1_oe <= 8'h00;
      p2_out <= 8'h00;
      p2_oe <= 8'h00;
      p3_out <= 4'h0;
      p4_out <= 8'h00;
      p4_oe <= 8'h00;
      p5_out <= 8'h00;
      p5_oe <= 8'h00;
      addr_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      rw_n <= 1'b1;
      strobe_oe <= 1'b0;
      timer_in <= 1'b0;
    end
    else
    begin
      // Address nibbles of P0 carry upper address; rest plain I/O
      p0_out[3:0] <= p01m_q[`IOP_B_P0_LO_ADDR] ? ba_q[11:8] : p0_dq[3:0];
      p0_out[7:4] <= p01m_q[`IOP_B_P0_HI_ADDR] ? ba_q[15:12] : p0_dq[7:4];
      p0_oe[3:0] <= p01m_q[`IOP_B_P0_LO_ADDR] ? {4{~bus_float}} : ~p0_dir_q[3:0];
      p0_oe[7:4] <= p01m_q[`IOP_B_P0_HI_ADDR] ? {4{~bus_float}} : ~p0_dir_q[7:4];
      if (p1_bus)
      begin
        p1_out <= st_q == S_ADDR ? ba_q[7:0] : bw_q;
        p1_oe <= {8{~bus_float & (st_q == S_ADDR | (st_q != S_IDLE & bwe_q))}};
      end
      else
      begin
        p1_out <= p1_dq;
        p1_oe <= ~p1_dir_q;
      end
      p2_out <= p2_dq;
      p2_oe <= drv_oe(p2_dir_q, p3m_q[`IOP_B_P2_OD], p2_dq);
      p4_out <= p4_dq;
      p4_oe <= drv_oe(p4_dir_q, p45d_q[0], p4_dq);
      p5_out <= p5_dq;
      p5_oe <= drv_oe(p5_dir_q, p45d_q[1], p5_dq);
      // Control port outputs always driven; alternate functions first
      if (p3m_q[`IOP_B_DM_EN])
        p3_out[0] <= ~bdm_q;
      else
        p3_out[0] <= hs_en[1] ? hs_line[1] : p3_dq[4];
      p3_out[1] <= hs_en[0] ? hs_line[0] : p3_dq[5];
      if (p3m_q[`IOP_B_TOUT_EN])
        p3_out[2] <= timer_out;
      else
        p3_out[2] <= hs_en[2] ? hs_line[2] : p3_dq[6];
      p3_out[3] <= p3_dq[7];
      timer_in <= f_p3[0];
      addr_strobe_n <= st_q != S_ADDR;
      data_strobe_n <= st_q != S_DATA;
      rw_n <= ~(bwe_q & st_q != S_IDLE);
      strobe_oe <= ~bus_float;
    end
  end

endmodule // iop_ports
